//--- pkg/dtpb_defines.svh
// constants of the driver telemetry packet builder
//==========================================================
// Behaviour
// - selector is 111 status, 101 external temp, 110 board temp.
// - rotation is 31 status, board temp, 31 status, external temp.
// - a short-circuit detection restarts the payload rotation.
// - payload refreshed per packet; temperatures refresh on their own strobes.
// - status word is 12 bits, bits 11..8 unused.
// - status bit 7 is one while the gate is held blocked.
// - status bit 6 is the OR of short-circuit and both undervoltage faults.
// - status bit 5 reports the self-test warning.
// - status bit 4 is one while turn-on is commanded.
// - status bits 3 and 2 report positive and negative rail undervoltage.
// - status bits 1 and 0 report on-state and off-state gate warnings.
// - temperature code is 0.5 K per step, zero at minus forty.
// - an open thermistor reports the minimum temperature code.
// - CRC covers link 5..0, link 11..6, payload 5..0, 11..6, selector.
// - CRC polynomial x^3+x+1, zero initial value, right shifting.
// - undervoltage is filtered for 4.0 us before set or clear.
// - command pulses shorter than 3.2 us are ignored.
// - a frame with the fault flag completes 1.9 to 4.2 us after detection.
// - the fault flag stays in the stream for 3 to 5 frames.
// - a fault blocks the gate for 20 ms, status bit 7 set throughout.
// - frame is start, six data LSB first, flag, even parity, stop.
// - logic low and idle are light on, logic high is light off.
// - packets of five frames with idle gap, shortened for a fault.
`ifndef DTPB_DEFINES_SVH
`define DTPB_DEFINES_SVH
`define DTPB_CLK_NS       100
`define DTPB_BIT_NS       200
`define DTPB_IDLE_NS      3300
`define DTPB_UV_FILT_NS   4000
`define DTPB_CMD_FILT_NS  3200
`define DTPB_SC_MIN_NS    1900
`define DTPB_SC_MAX_NS    4200
`define DTPB_BLOCK_NS     20000000
`define DTPB_SEL_STATUS   3'h7
`define DTPB_SEL_EXT      3'h5
`define DTPB_SEL_BOARD    3'h6
`define DTPB_SLOT_BOARD   6'h1f
`define DTPB_SLOT_EXT     6'h3f
`define DTPB_FRAME_LAST   4'h9
`define DTPB_PKT_LAST     3'h4
`define DTPB_FLAG_FRAMES  3'h4
`define DTPB_TEMP_MAX     12'h154
`define DTPB_TEMP_OPEN    12'h000
`define DTPB_CRC_REFL     3'h6
`endif

//--- pkg/dtpb_pkg.sv
// types of the driver telemetry packet builder
package dtpb_pkg;
   // fields of one packet, latched at packet start
   typedef struct packed {
      logic [11:0] link_voltage_word;
      logic [11:0] payload_word;
      logic [2:0]  sel;
      logic [2:0]  crc;
   } dtpb_pkt_t;

   typedef enum logic {
      DTPB_IDLE,
      DTPB_SEND
   } dtpb_state_t;
endpackage : dtpb_pkg

//--- design/dtpb_top.sv
// telemetry packet builder, command and undervoltage filters, gate block
`timescale 1ns/1ps
`include "dtpb_defines.svh"
module dtpb_top
   import dtpb_pkg::*;
#(
   parameter int BLOCK_CYC = `DTPB_BLOCK_NS / `DTPB_CLK_NS
)(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // command and fault inputs
   input  wire logic        opt_cmd_in,
   input  wire logic        desat_fault_flag,
   input  wire logic        pos_rail_uv_raw,
   input  wire logic        neg_rail_uv_raw,
   input  wire logic        selftest_warn_flag,
   input  wire logic        on_gate_voltage_warn,
   input  wire logic        off_gate_voltage_warn,
   // measurements
   input  wire logic [11:0] link_voltage_word,
   input  wire logic [11:0] board_temp_raw,
   input  wire logic        board_temp_refresh,
   input  wire logic        board_ntc_open,
   input  wire logic [11:0] ext_temp_raw,
   input  wire logic        ext_temp_refresh,
   input  wire logic        ext_ntc_open,
   // outputs
   output logic             optical_status_output,
   output logic             gate_on,
   output logic [11:0]      driver_status_word
);
   //==========================================================
   // timing counts
   localparam int BIT_CYC  = `DTPB_BIT_NS / `DTPB_CLK_NS;
   localparam int IDLE_CYC = `DTPB_IDLE_NS / `DTPB_CLK_NS;
   localparam int UV_CYC   =
      (`DTPB_UV_FILT_NS + `DTPB_CLK_NS - 1) / `DTPB_CLK_NS;
   localparam int CMD_CYC  =
      (`DTPB_CMD_FILT_NS + `DTPB_CLK_NS - 1) / `DTPB_CLK_NS;
   localparam int REP_MIN  = `DTPB_SC_MIN_NS / `DTPB_CLK_NS;
   localparam int REP_MAX  = `DTPB_SC_MAX_NS / `DTPB_CLK_NS;

   //==========================================================
   // functions
   function automatic logic [5:0] filt_lim(input int ch);
      filt_lim = (ch == 0) ? 6'(CMD_CYC - 1) : 6'(UV_CYC - 1);
   endfunction : filt_lim

   function automatic logic [11:0] temp_code(input logic [11:0] raw,
                                             input logic        open);
      if (open)
         temp_code = `DTPB_TEMP_OPEN;
      else if (raw > `DTPB_TEMP_MAX)
         temp_code = `DTPB_TEMP_MAX;
      else
         temp_code = raw;
   endfunction : temp_code

   // reflected form of x^3+x+1, fed lsb first, field order fixed
   function automatic logic [2:0] crc3(input logic [26:0] bits);
      logic [2:0] c;
      logic       fb;
      c = 3'h0;
      for (int i = 0; i < 27; i++)
      begin
         fb = c[0] ^ bits[i];
         c  = {1'b0, c[2:1]} ^ (fb ? `DTPB_CRC_REFL : 3'h0);
      end
      crc3 = c;
   endfunction : crc3

   function automatic logic [9:0] frame_bits(input dtpb_pkt_t p,
                                             input logic [2:0] idx,
                                             input logic      sc);
      logic [5:0] d;
      case (idx)
         3'h0:    d = p.link_voltage_word[5:0];
         3'h1:    d = p.link_voltage_word[11:6];
         3'h2:    d = p.payload_word[5:0];
         3'h3:    d = p.payload_word[11:6];
         default: d = {p.sel, p.crc};
      endcase
      // stop is logic low so that it shows as light on
      frame_bits = {1'b0, ^{sc, d}, sc, d, 1'b1};
   endfunction : frame_bits

   //==========================================================
   // signals
   logic [2:0]  filt_raw;
   logic [2:0]  filt_q;
   logic [5:0]  filt_cnt_q [3];
   logic        cmd_q, uv_pos_q, uv_neg_q;
   logic        uv_pos_d_q, uv_neg_d_q;
   logic        desat_d_q, desat_lat_q;
   logic        desat_rise, uv_rise;
   logic [31:0] blk_cnt_q;
   logic        blocked;
   logic [11:0] board_temp_q, ext_temp_q, status_q;
   logic [5:0]  slot_q, pkt_slot;
   dtpb_pkt_t   pkt_d, pkt_q;
   dtpb_state_t state_q;
   logic [5:0]  idle_cnt_q;
   logic [2:0]  frame_idx_q;
   logic [3:0]  bit_idx_q;
   logic [1:0]  phase_q;
   logic [9:0]  sh_q;
   logic        light_q, sc_cur_q;
   logic [2:0]  flag_cnt_q;
   logic        pkt_start, frame_end, load, sc_now;

   //==========================================================
   // command and undervoltage filters
   assign filt_raw = {neg_rail_uv_raw, pos_rail_uv_raw, opt_cmd_in};
   assign cmd_q    = filt_q[0];
   assign uv_pos_q = filt_q[1];
   assign uv_neg_q = filt_q[2];

   // level only follows after it differs for the whole filter time
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         filt_q <= 3'h0;
         for (int i = 0; i < 3; i++)
            filt_cnt_q[i] <= 6'h00;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (filt_raw[i] == filt_q[i])
               filt_cnt_q[i] <= 6'h00;
            else if (filt_cnt_q[i] == filt_lim(i))
            begin
               filt_q[i]     <= filt_raw[i];
               filt_cnt_q[i] <= 6'h00;
            end
            else
               filt_cnt_q[i] <= filt_cnt_q[i] + 6'h01;
         end
      end
   end

   //==========================================================
   // fault edges, blocking period
   assign desat_rise = desat_fault_flag & ~desat_d_q;
   assign uv_rise    = (uv_pos_q & ~uv_pos_d_q) | (uv_neg_q & ~uv_neg_d_q);
   assign blocked    = (blk_cnt_q != 32'h0);

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         desat_d_q  <= 1'b0;
         uv_pos_d_q <= 1'b0;
         uv_neg_d_q <= 1'b0;
         blk_cnt_q  <= 32'h0;
      end
      else
      begin
         desat_d_q  <= desat_fault_flag;
         uv_pos_d_q <= uv_pos_q;
         uv_neg_d_q <= uv_neg_q;
         if (desat_rise || uv_rise)
            blk_cnt_q <= 32'(BLOCK_CYC);
         else if (blocked)
            blk_cnt_q <= blk_cnt_q - 32'h1;
      end
   end

   // set wins over the clear
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         desat_lat_q <= 1'b0;
      else if (desat_rise)
         desat_lat_q <= 1'b1;
      else if (!blocked && !desat_fault_flag)
         desat_lat_q <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         gate_on <= 1'b0;
      else
         gate_on <= cmd_q & ~blocked & ~desat_rise &
                    ~uv_pos_q & ~uv_neg_q;
   end

   //==========================================================
   // temperatures and status word
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         board_temp_q <= `DTPB_TEMP_OPEN;
         ext_temp_q   <= `DTPB_TEMP_OPEN;
      end
      else
      begin
         if (board_temp_refresh)
            board_temp_q <= temp_code(board_temp_raw, board_ntc_open);
         if (ext_temp_refresh)
            ext_temp_q <= temp_code(ext_temp_raw, ext_ntc_open);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         status_q <= 12'h000;
      else
      begin
         status_q[11:8] <= 4'h0;
         status_q[7]    <= blocked;
         status_q[6]    <= desat_lat_q | uv_pos_q | uv_neg_q;
         status_q[5]    <= selftest_warn_flag;
         status_q[4]    <= cmd_q;
         status_q[3]    <= uv_pos_q;
         status_q[2]    <= uv_neg_q;
         status_q[1]    <= on_gate_voltage_warn;
         status_q[0]    <= off_gate_voltage_warn;
      end
   end
   assign driver_status_word = status_q;

   //==========================================================
   // payload rotation and packet assembly
   assign pkt_slot = desat_rise ? 6'h00 : slot_q;

   always_comb
   begin
      pkt_d.link_voltage_word = link_voltage_word;
      case (pkt_slot)
         `DTPB_SLOT_BOARD:
         begin
            pkt_d.payload_word = board_temp_q;
            pkt_d.sel          = `DTPB_SEL_BOARD;
         end
         `DTPB_SLOT_EXT:
         begin
            pkt_d.payload_word = ext_temp_q;
            pkt_d.sel          = `DTPB_SEL_EXT;
         end
         default:
         begin
            pkt_d.payload_word = status_q;
            pkt_d.sel          = `DTPB_SEL_STATUS;
         end
      endcase
      pkt_d.crc = crc3({pkt_d.sel, pkt_d.payload_word[11:6],
                        pkt_d.payload_word[5:0],
                        link_voltage_word[11:6],
                        link_voltage_word[5:0]});
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         slot_q <= 6'h00;
         pkt_q  <= '0;
      end
      else if (pkt_start)
      begin
         slot_q <= pkt_slot + 6'h01;
         pkt_q  <= pkt_d;
      end
      else if (desat_rise)
         slot_q <= 6'h00;
   end

   //==========================================================
   // packet scheduler
   // a pending fault flag cuts the idle gap short
   assign pkt_start = (state_q == DTPB_IDLE) &&
                      ((idle_cnt_q == 6'(IDLE_CYC - 1)) ||
                       desat_rise || (flag_cnt_q != 3'h0));
   assign frame_end = (state_q == DTPB_SEND) &&
                      (phase_q == 2'(BIT_CYC - 1)) &&
                      (bit_idx_q == `DTPB_FRAME_LAST);
   assign load      = pkt_start ||
                      (frame_end && frame_idx_q != `DTPB_PKT_LAST);
   assign sc_now    = desat_rise || (flag_cnt_q != 3'h0);

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q     <= DTPB_IDLE;
         idle_cnt_q  <= 6'h00;
         frame_idx_q <= 3'h0;
      end
      else
      begin
         case (state_q)
            DTPB_IDLE:
            begin
               idle_cnt_q <= idle_cnt_q + 6'h01;
               if (pkt_start)
               begin
                  state_q     <= DTPB_SEND;
                  frame_idx_q <= 3'h0;
               end
            end
            DTPB_SEND:
            begin
               idle_cnt_q <= 6'h00;
               if (frame_end)
               begin
                  if (frame_idx_q == `DTPB_PKT_LAST)
                     state_q <= DTPB_IDLE;
                  else
                     frame_idx_q <= frame_idx_q + 3'h1;
               end
            end
            default: state_q <= DTPB_IDLE;
         endcase
      end
   end

   // fault flag rides in a fixed number of frames after detection
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         flag_cnt_q <= 3'h0;
      else if (desat_rise)
         flag_cnt_q <= load ? `DTPB_FLAG_FRAMES - 3'h1
                            : `DTPB_FLAG_FRAMES;
      else if (load && flag_cnt_q != 3'h0)
         flag_cnt_q <= flag_cnt_q - 3'h1;
   end

   //==========================================================
   // frame serializer, light on for logic low and idle
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sh_q      <= 10'h3ff;
         bit_idx_q <= 4'h0;
         phase_q   <= 2'h0;
         light_q   <= 1'b1;
         sc_cur_q  <= 1'b0;
      end
      else if (load)
      begin
         // next frame index is zero on packet start
         sh_q      <= frame_bits(pkt_start ? pkt_d : pkt_q,
                                 pkt_start ? 3'h0 : frame_idx_q + 3'h1,
                                 sc_now);
         light_q   <= 1'b0;
         sc_cur_q  <= sc_now;
         bit_idx_q <= 4'h0;
         phase_q   <= 2'h0;
      end
      else if (state_q == DTPB_SEND)
      begin
         if (phase_q == 2'(BIT_CYC - 1))
         begin
            phase_q <= 2'h0;
            if (frame_end)
               light_q <= 1'b1;
            else
            begin
               bit_idx_q <= bit_idx_q + 4'h1;
               sh_q      <= {1'b1, sh_q[9:1]};
               light_q   <= ~sh_q[1];
            end
         end
         else
            phase_q <= phase_q + 2'h1;
      end
   end
   assign optical_status_output = light_q;

   //==========================================================
   // checks
   AST_SEL_LEGAL: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state_q == DTPB_SEND) |-> (pkt_q.sel inside
         {`DTPB_SEL_STATUS, `DTPB_SEL_EXT, `DTPB_SEL_BOARD}))
      else $error("reserved selector sent");
   AST_UNUSED_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n)
      (pkt_start && pkt_d.sel == `DTPB_SEL_STATUS) |=>
         (pkt_q.payload_word[11:8] == 4'h0))
      else $error("unused status bits not zero");
   AST_BLOCK_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
      desat_rise |=> ##1 status_q[7] [*8])
      else $error("gate block bit not held");
   AST_SUM_FAIL: assert property (@(posedge core_clk) disable iff (!arst_n)
      (uv_pos_q || uv_neg_q || desat_lat_q) |=> status_q[6])
      else $error("sum failure bit missing");
   AST_CMD_FILTER: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(cmd_q) |-> ($past(opt_cmd_in) == cmd_q) &&
         ($past(opt_cmd_in, CMD_CYC) == cmd_q))
      else $error("short command pulse accepted");
   AST_UV_FILTER: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(uv_pos_q) |-> $past(pos_rail_uv_raw, UV_CYC))
      else $error("undervoltage not filtered");
   AST_DESAT_REPORT: assert property (@(posedge core_clk) disable iff (!arst_n)
      desat_rise |-> ##[REP_MIN:REP_MAX] (frame_end && sc_cur_q))
      else $error("fault frame too late");
   AST_FLAG_LOAD: assert property (@(posedge core_clk) disable iff (!arst_n)
      (desat_rise && !load) |=> (flag_cnt_q == `DTPB_FLAG_FRAMES))
      else $error("fault flag hold not loaded");
   AST_ROT_RESTART: assert property (@(posedge core_clk) disable iff (!arst_n)
      (desat_rise && !pkt_start) |=> (slot_q == 6'h00))
      else $error("rotation not restarted");
   AST_IDLE_LIGHT: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state_q == DTPB_IDLE && !$past(load)) |-> light_q)
      else $error("idle line not light on");
   AST_TEMP_OPEN: assert property (@(posedge core_clk) disable iff (!arst_n)
      (board_temp_refresh && board_ntc_open) |=>
         (board_temp_q == `DTPB_TEMP_OPEN))
      else $error("open thermistor not minimum");
endmodule : dtpb_top

//--- tb/dtpb_host_model.sv
// host-side receiver model that decodes the optical telemetry stream
`timescale 1ns/1ps
module dtpb_host_model
   import dtpb_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // optical line, 1 = light on
   input  wire logic optical_status_output,
   // decoded packets
   output logic       pkt_valid,
   output logic       pkt_ok,
   output dtpb_pkt_t  pkt,
   output logic [4:0] pkt_flags,
   output logic       flag_frame_done
);
   logic        busy_q;
   logic [4:0]  cnt_q;
   logic [9:0]  bits_q;
   logic [2:0]  frm_q;
   logic [23:0] dat_q;
   logic [3:0]  flg_q;
   logic        bad_q;
   logic        bit_v;
   logic [9:0]  w;
   logic [29:0] d;
   logic        frm_bad;

   function automatic logic [2:0] crc3(input logic [26:0] b);
      logic [2:0] c;
      logic       fb;
      c = 3'h0;
      for (int i = 0; i < 27; i++)
      begin
         fb = c[0] ^ b[i];
         c = (c >> 1) ^ (fb ? 3'h6 : 3'h0);
      end
      return c;
   endfunction : crc3

   assign bit_v = ~optical_status_output;
   assign w     = {bit_v, bits_q[9:1]};
   // start is light off, stop light on, even parity over data and flag
   assign frm_bad = !w[0] || w[9] || ^w[8:1];
   assign d       = {w[6:1], dat_q};

   //==========================================================
   // frame and packet assembly, sampled mid-bit
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy_q          <= 1'b0;
         cnt_q           <= 5'h0;
         frm_q           <= 3'h0;
         bad_q           <= 1'b0;
         pkt_valid       <= 1'b0;
         pkt_ok          <= 1'b0;
         flag_frame_done <= 1'b0;
      end
      else
      begin
         pkt_valid       <= 1'b0;
         flag_frame_done <= 1'b0;
         if (!busy_q)
         begin
            // the start bit is kept so that it lands in w[0]
            bits_q <= w;
            busy_q <= bit_v;
            cnt_q  <= 5'h1;
         end
         else
         begin
            cnt_q <= cnt_q + 5'h1;
            if (!cnt_q[0])
               bits_q <= w;
            if (cnt_q == 5'h12)
            begin
               busy_q          <= 1'b0;
               flag_frame_done <= w[7];
               if (frm_q == 3'h4)
               begin
                  frm_q     <= 3'h0;
                  bad_q     <= 1'b0;
                  pkt_valid <= 1'b1;
                  pkt       <= {d[11:0], d[23:12], d[29:24]};
                  pkt_flags <= {w[7], flg_q};
                  // reserved selectors and bad checks are discarded
                  pkt_ok <= !bad_q && !frm_bad && d[29] && |d[28:27]
                     && crc3({d[29:27], d[23:0]}) == d[26:24];
               end
               else
               begin
                  frm_q <= frm_q + 3'h1;
                  dat_q <= {w[6:1], dat_q[23:6]};
                  flg_q <= {w[7], flg_q[3:1]};
                  bad_q <= bad_q | frm_bad;
               end
            end
         end
      end
   end
endmodule : dtpb_host_model

//--- tb/driver_telemetry_packet_builder_test.sv
// self-checking bench of the driver telemetry packet builder
`timescale 1ns/1ps
`include "dtpb_defines.svh"
`define CHK(a, b) \
   begin \
      compares++; \
      if ((a) !== (b)) \
      begin \
         err_count++; \
         $display("[FAIL] %0t ns: got %h, want %h", $time, (a), (b)); \
      end \
   end
module driver_telemetry_packet_builder_test
   import dtpb_pkg::*;
;
   logic        core_clk, arst_n, opt_cmd_in, desat_fault_flag;
   logic        pos_rail_uv_raw, neg_rail_uv_raw, selftest_warn_flag;
   logic        on_gate_voltage_warn, off_gate_voltage_warn;
   logic        board_temp_refresh, board_ntc_open;
   logic        ext_temp_refresh, ext_ntc_open;
   logic        optical_status_output, gate_on;
   logic [11:0] link_voltage_word, board_temp_raw, ext_temp_raw;
   logic [11:0] driver_status_word, exp_st;
   logic        pkt_valid, pkt_ok, flag_frame_done;
   logic [4:0]  pkt_flags;
   dtpb_pkt_t   pkt;
   int          err_count, compares, n;

   // short block period keeps the fault scenario brief
   dtpb_top #(.BLOCK_CYC(50)) uut (
      .core_clk, .arst_n, .opt_cmd_in, .desat_fault_flag,
      .pos_rail_uv_raw, .neg_rail_uv_raw, .selftest_warn_flag,
      .on_gate_voltage_warn, .off_gate_voltage_warn,
      .link_voltage_word, .board_temp_raw, .board_temp_refresh,
      .board_ntc_open, .ext_temp_raw, .ext_temp_refresh, .ext_ntc_open,
      .optical_status_output, .gate_on, .driver_status_word
   );

   dtpb_host_model host (
      .core_clk, .arst_n, .optical_status_output,
      .pkt_valid, .pkt_ok, .pkt, .pkt_flags, .flag_frame_done
   );

   //==========================================================
   // helpers
   task automatic close_out();
      $display("compares %0d, errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc

   task automatic wait_pkt();
      int i;
      i = 0;
      do
      begin
         @(negedge core_clk);
         i++;
      end
      while (pkt_valid !== 1'b1 && i < 400);
      if (pkt_valid !== 1'b1)
      begin
         err_count++;
         $display("[FAIL] %0t ns: no packet", $time);
         close_out();
      end
   endtask : wait_pkt

   // n packets from rotation slot s0, inputs held steady meanwhile
   task automatic rot(input int cnt, input int s0);
      int         s;
      logic [2:0]  esel;
      logic [11:0] epay;
      for (int k = 0; k < cnt; k++)
      begin
         s = (s0 + k) % 64;
         esel = s == 31 ? `DTPB_SEL_BOARD
              : s == 63 ? `DTPB_SEL_EXT : `DTPB_SEL_STATUS;
         epay = s == 31 ? 12'h154 : s == 63 ? 12'h000 : exp_st;
         wait_pkt();
         `CHK(pkt_ok, 1'b1)
         `CHK(pkt.link_voltage_word, link_voltage_word)
         `CHK(pkt.sel, esel)
         `CHK(pkt.payload_word, epay)
      end
   endtask : rot

   initial
   begin
      core_clk = 1'b0;
      forever
         #50 core_clk = ~core_clk;
   end

   //==========================================================
   // main sequence
   initial
   begin
      {arst_n, opt_cmd_in, desat_fault_flag, pos_rail_uv_raw} = 4'h0;
      {neg_rail_uv_raw, off_gate_voltage_warn} = 2'h0;
      {selftest_warn_flag, on_gate_voltage_warn} = 2'h3;
      {board_temp_refresh, ext_temp_refresh} = 2'h0;
      {board_ntc_open, ext_ntc_open} = 2'h1;
      link_voltage_word = 12'ha5c;
      board_temp_raw = 12'h154;
      ext_temp_raw = 12'h0aa;
      exp_st = 12'h022;
      err_count = 0;
      compares = 0;
      cyc(8);
      `CHK(optical_status_output, 1'b1)
      `CHK({gate_on, driver_status_word}, 13'h0000)
      arst_n = 1'b1;
      cyc(1);
      {board_temp_refresh, ext_temp_refresh} = 2'h3;
      cyc(1);
      {board_temp_refresh, ext_temp_refresh} = 2'h0;
      `CHK(driver_status_word, exp_st)
      rot(64, 0);
      // command pulses shorter than the filter must not move the gate
      opt_cmd_in = 1'b1;
      cyc(30);
      `CHK({gate_on, driver_status_word[4]}, 2'h0)
      opt_cmd_in = 1'b0;
      cyc(5);
      opt_cmd_in = 1'b1;
      cyc(36);
      `CHK({gate_on, driver_status_word[4]}, 2'h3)
      opt_cmd_in = 1'b0;
      cyc(30);
      `CHK({gate_on, driver_status_word[4]}, 2'h3)
      opt_cmd_in = 1'b1;
      exp_st = 12'h032;
      pos_rail_uv_raw = 1'b1;
      cyc(38);
      `CHK(driver_status_word[3], 1'b0)
      pos_rail_uv_raw = 1'b0;
      cyc(5);
      for (int r = 0; r < 2; r++)
      begin
         {pos_rail_uv_raw, neg_rail_uv_raw} = r ? 2'h1 : 2'h2;
         cyc(45);
         `CHK({gate_on, driver_status_word[7:2]}, r ? 7'h3d : 7'h3e)
         {pos_rail_uv_raw, neg_rail_uv_raw} = 2'h0;
         cyc(38);
         `CHK(driver_status_word[3:2], r ? 2'h1 : 2'h2)
         cyc(100);
         `CHK({gate_on, driver_status_word}, {1'b1, exp_st})
      end
      off_gate_voltage_warn = 1'b1;
      cyc(2);
      `CHK(driver_status_word[1:0], 2'h3)
      off_gate_voltage_warn = 1'b0;
      // short circuit raised in the idle gap after a packet
      wait_pkt();
      cyc(5);
      desat_fault_flag = 1'b1;
      n = 0;
      do
      begin
         cyc(1);
         n++;
         if (n == 3)
            desat_fault_flag = 1'b0;
      end
      while (flag_frame_done !== 1'b1 && n < 60);
      `CHK(n >= 19 && n <= 42, 1'b1)
      if (n >= 60)
         close_out();
      cyc(46 - n);
      `CHK({gate_on, driver_status_word[7:6]}, 3'h3)
      cyc(10);
      `CHK({gate_on, driver_status_word[7:6]}, 3'h4)
      wait_pkt();
      `CHK(pkt.sel, `DTPB_SEL_STATUS)
      `CHK($countones(pkt_flags) inside {[3:5]}, 1'b1)
      rot(63, 1);
      close_out();
   end
endmodule : driver_telemetry_packet_builder_test
